// file: common/irq_ctrl_pkg.sv
// Purpose: constants shared by the interrupt controller
// Assumes: one MCLK cycle per quarter-phase, four per instruction cycle
// Notes: register indices are word indices; byte address is index times four
package irq_ctrl_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [11:0] IDX_INTERRUPT_CONTROL = 12'h000b;
    localparam logic [11:0] IDX_PERIPHERAL_FLAGS = 12'h000c;
    localparam logic [11:0] IDX_PERIPHERAL_ENABLES = 12'h008c;
    localparam logic [11:0] IDX_OPTION = 12'h0081;
    localparam logic [11:0] IDX_PIN_CHANGE_ENABLES = 12'h0096;
    localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'hff;
    localparam logic [5:0] RST_PIN_CHANGE = 6'h00;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int B_GLOBAL_EN = 7;
    localparam int B_PERIPH_EN = 6;
    localparam int B_TIMER0_EN = 5;
    localparam int B_EXTIE = 4;
    localparam int B_PCIE = 3;
    localparam int B_TIMER0_FLAG = 2;
    localparam int B_EXTIF = 1;
    localparam int B_PCIF = 0;
    localparam int B_NVM = 7;
    localparam int B_ADC = 6;
    localparam int B_CMP = 3;
    localparam int B_TMR1 = 0;
    localparam int B_EDGE = 6;
    localparam logic [7:0] PERIPH_MASK = 8'hc9;
    localparam logic [7:0] CTRL_FLAG_MASK = 8'h07;
    // ----------------------------------------
    // phases, vector and entry timing
    // ----------------------------------------
    localparam logic [1:0] PH_ONE = 2'h0;
    localparam logic [1:0] PH_TWO = 2'h1;
    localparam logic [1:0] PH_FOUR = 2'h3;
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;
    localparam logic [1:0] ENTRY_CYCLES = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_VECTOR = 2'b10
    } entry_state_type;
endpackage

// file: core/mcu_interrupt_controller.sv
// Purpose: interrupt flags, enables and vectoring for a small 8-bit core
// Assumes: event inputs are one-cycle pulses synchronous to MCLK
// Notes: registers reached over AXI4-Lite, one aligned word each
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module mcu_interrupt_controller (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // axi4-lite slave
    input wire logic [13:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [13:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // event sources
    input wire logic EXT_IRQ_PIN,
    input wire logic TIMER0_ROLLOVER,
    input wire logic [5:0] PORT_PINS,
    input wire logic COMPARATOR_CHANGE,
    input wire logic CONVERSION_DONE,
    input wire logic TIMER1_ROLLOVER,
    input wire logic NVM_WRITE_DONE,
    // core sequencer
    input wire logic RETURN_FROM_HANDLER,
    input wire logic SLEEPING,
    output logic IRQ_REQ,
    output logic WAKE_REQ,
    output logic PUSH_RETURN,
    output logic VECTOR_LOAD,
    output logic [12:0] VECTOR_PC,
    output logic [1:0] PHASE
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [1:0] phase_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] pflags_ff;
    logic [7:0] penable_ff;
    logic [7:0] option_ff;
    logic [5:0] pin_change_en_ff;
    logic ext_pin_ff;
    logic ext_edge_pend_ff;
    logic [5:0] port_last_ff;
    irq_ctrl_pkg::entry_state_type state_ff;
    irq_ctrl_pkg::entry_state_type nxt_state;
    logic [1:0] wait_cnt_ff;
    logic aw_full_ff;
    logic [11:0] aw_idx_ff;
    logic w_full_ff;
    logic [7:0] w_data_ff;
    logic w_lane_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic irq_req_ff;
    logic wake_ff;
    logic vector_ff;
    logic [12:0] vector_pc_ff;
    // ----------------------------------------
    // combinational terms
    // ----------------------------------------
    logic phase_one;
    logic do_write;
    logic wr_ctrl;
    logic wr_pflags;
    logic ext_edge;
    logic ext_set;
    logic port_set;
    logic [7:0] ctrl_set;
    logic [7:0] periph_set;
    logic periph_pending;
    logic ctrl_pending;
    logic any_pending;
    logic global_clear_write;
    logic take;
    logic nxt_aw_full;
    logic nxt_w_full;
    logic [11:0] ar_idx;
    logic [7:0] rd_byte;
    logic rd_hit;

    assign phase_one = (phase_ff == irq_ctrl_pkg::PH_ONE);
    assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
    assign wr_ctrl = do_write && w_lane_ff && (aw_idx_ff == irq_ctrl_pkg::IDX_INTERRUPT_CONTROL);
    assign wr_pflags = do_write && w_lane_ff && (aw_idx_ff == irq_ctrl_pkg::IDX_PERIPHERAL_FLAGS);
    // edge chosen by the option register; the old pin level is held for comparison
    assign ext_edge = option_ff[irq_ctrl_pkg::B_EDGE] ? (EXT_IRQ_PIN && !ext_pin_ff)
                                                      : (!EXT_IRQ_PIN && ext_pin_ff);
    // an edge seen in phases two or three waits for phase four to land
    assign ext_set = (ext_edge || ext_edge_pend_ff)
                     && (phase_ff == irq_ctrl_pkg::PH_FOUR || phase_one);
    // the port is read at the start of phase two; a change there is dropped
    assign port_set = |((PORT_PINS ^ port_last_ff) & pin_change_en_ff)
                      && (phase_ff != irq_ctrl_pkg::PH_TWO);
    assign ctrl_set = {5'h00, TIMER0_ROLLOVER, ext_set, port_set};
    assign periph_set = {NVM_WRITE_DONE, CONVERSION_DONE, 2'h0,
                         COMPARATOR_CHANGE, 2'h0, TIMER1_ROLLOVER};
    assign ctrl_pending = |(ctrl_ff[irq_ctrl_pkg::B_TIMER0_FLAG:irq_ctrl_pkg::B_PCIF]
                            & ctrl_ff[irq_ctrl_pkg::B_TIMER0_EN:irq_ctrl_pkg::B_PCIE]);
    assign periph_pending = |(pflags_ff & penable_ff & irq_ctrl_pkg::PERIPH_MASK);
    assign any_pending = ctrl_pending || (periph_pending && ctrl_ff[irq_ctrl_pkg::B_PERIPH_EN]);
    assign global_clear_write = wr_ctrl && !w_data_ff[irq_ctrl_pkg::B_GLOBAL_EN];
    // an instruction clearing the global enable beats an entry due this cycle
    assign take = (state_ff == irq_ctrl_pkg::ST_IDLE) && phase_one && any_pending
                  && ctrl_ff[irq_ctrl_pkg::B_GLOBAL_EN] && !global_clear_write;

    // ----------------------------------------
    // quarter-phase counter and sampling
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            phase_ff <= irq_ctrl_pkg::PH_ONE;
            ext_pin_ff <= 1'b0;
            ext_edge_pend_ff <= 1'b0;
            port_last_ff <= irq_ctrl_pkg::RST_PIN_CHANGE;
        end
        else
        begin
            phase_ff <= phase_ff + 2'h1;
            ext_pin_ff <= EXT_IRQ_PIN;
            ext_edge_pend_ff <= (ext_edge || ext_edge_pend_ff) && !ext_set;
            port_last_ff <= PORT_PINS;
        end
    end

    // ----------------------------------------
    // control register; a flag set wins over a clearing write, entry beats return for the global enable
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl_ff <= irq_ctrl_pkg::RST_INTERRUPT_CONTROL;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (i == irq_ctrl_pkg::B_GLOBAL_EN)
                begin
                    if (take)
                        ctrl_ff[i] <= 1'b0;
                    else if (RETURN_FROM_HANDLER)
                        ctrl_ff[i] <= 1'b1;
                    else if (wr_ctrl)
                        ctrl_ff[i] <= w_data_ff[i];
                end
                else if (irq_ctrl_pkg::CTRL_FLAG_MASK[i])
                begin
                    ctrl_ff[i] <= ctrl_set[i] | (wr_ctrl ? w_data_ff[i] : ctrl_ff[i]);
                end
                else if (wr_ctrl)
                begin
                    ctrl_ff[i] <= w_data_ff[i];
                end
            end
        end
    end

    // ----------------------------------------
    // peripheral flags, enables, option, pin-change enables
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pflags_ff <= irq_ctrl_pkg::RST_PERIPHERAL;
            penable_ff <= irq_ctrl_pkg::RST_PERIPHERAL;
            option_ff <= irq_ctrl_pkg::RST_OPTION;
            pin_change_en_ff <= irq_ctrl_pkg::RST_PIN_CHANGE;
        end
        else
        begin
            pflags_ff <= (periph_set | (wr_pflags ? w_data_ff : pflags_ff))
                         & irq_ctrl_pkg::PERIPH_MASK;
            if (do_write && w_lane_ff)
            begin
                if (aw_idx_ff == irq_ctrl_pkg::IDX_PERIPHERAL_ENABLES)
                    penable_ff <= w_data_ff & irq_ctrl_pkg::PERIPH_MASK;
                if (aw_idx_ff == irq_ctrl_pkg::IDX_OPTION)
                    option_ff <= w_data_ff;
                if (aw_idx_ff == irq_ctrl_pkg::IDX_PIN_CHANGE_ENABLES)
                    pin_change_en_ff <= w_data_ff[5:0];
            end
        end
    end

    // ----------------------------------------
    // entry sequence: sample at phase one, vector two instruction cycles later
    // ----------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            irq_ctrl_pkg::ST_IDLE:
                if (take)
                    nxt_state = irq_ctrl_pkg::ST_WAIT;
            irq_ctrl_pkg::ST_WAIT:
                if (phase_one && wait_cnt_ff == irq_ctrl_pkg::ENTRY_CYCLES - 2'h1)
                    nxt_state = irq_ctrl_pkg::ST_VECTOR;
            irq_ctrl_pkg::ST_VECTOR:
                nxt_state = irq_ctrl_pkg::ST_IDLE;
            default:
                nxt_state = irq_ctrl_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_ff <= irq_ctrl_pkg::ST_IDLE;
            wait_cnt_ff <= 2'h0;
            vector_ff <= 1'b0;
            vector_pc_ff <= 13'h0000;
            irq_req_ff <= 1'b0;
            wake_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (state_ff != irq_ctrl_pkg::ST_WAIT)
                wait_cnt_ff <= 2'h0;
            else if (phase_one)
                wait_cnt_ff <= wait_cnt_ff + 2'h1;
            // only the return address is pushed; W and status are software's job
            vector_ff <= (nxt_state == irq_ctrl_pkg::ST_VECTOR);
            vector_pc_ff <= irq_ctrl_pkg::VECTOR_ADDR;
            irq_req_ff <= any_pending && ctrl_ff[irq_ctrl_pkg::B_GLOBAL_EN];
            // wake ignores the global enable; vectoring afterwards does not
            wake_ff <= SLEEPING && any_pending;
        end
    end

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    assign nxt_aw_full = do_write ? 1'b0 : (aw_full_ff || (AWVALID && awready_ff));
    assign nxt_w_full = do_write ? 1'b0 : (w_full_ff || (WVALID && wready_ff));

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            aw_idx_ff <= 12'h000;
            w_data_ff <= 8'h00;
            w_lane_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= irq_ctrl_pkg::RESP_OKAY;
        end
        else
        begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff <= nxt_w_full;
            awready_ff <= !nxt_aw_full;
            wready_ff <= !nxt_w_full;
            if (AWVALID && awready_ff)
                aw_idx_ff <= AWADDR[13:2];
            if (WVALID && wready_ff)
            begin
                w_data_ff <= WDATA[7:0];
                w_lane_ff <= WSTRB[0];
            end
            if (do_write)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= (aw_idx_ff == irq_ctrl_pkg::IDX_INTERRUPT_CONTROL
                             || aw_idx_ff == irq_ctrl_pkg::IDX_PERIPHERAL_FLAGS
                             || aw_idx_ff == irq_ctrl_pkg::IDX_PERIPHERAL_ENABLES
                             || aw_idx_ff == irq_ctrl_pkg::IDX_OPTION
                             || aw_idx_ff == irq_ctrl_pkg::IDX_PIN_CHANGE_ENABLES)
                            ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;
            end
            else if (BREADY)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    assign ar_idx = ARADDR[13:2];

    always_comb
    begin
        rd_hit = 1'b1;
        case (ar_idx)
            irq_ctrl_pkg::IDX_INTERRUPT_CONTROL: rd_byte = ctrl_ff;
            irq_ctrl_pkg::IDX_PERIPHERAL_FLAGS: rd_byte = pflags_ff;
            irq_ctrl_pkg::IDX_PERIPHERAL_ENABLES: rd_byte = penable_ff;
            irq_ctrl_pkg::IDX_OPTION: rd_byte = option_ff;
            irq_ctrl_pkg::IDX_PIN_CHANGE_ENABLES: rd_byte = {2'h0, pin_change_en_ff};
            default:
            begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= irq_ctrl_pkg::RESP_OKAY;
        end
        else if (ARVALID && arready_ff)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h00_0000, rd_byte};
            rresp_ff <= rd_hit ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;
        end
        else if (rvalid_ff)
        begin
            rvalid_ff <= !RREADY;
            arready_ff <= RREADY;
        end
        else
        begin
            arready_ff <= 1'b1;
        end
    end

    assign AWREADY = awready_ff;
    assign WREADY = wready_ff;
    assign BVALID = bvalid_ff;
    assign BRESP = bresp_ff;
    assign ARREADY = arready_ff;
    assign RVALID = rvalid_ff;
    assign RDATA = rdata_ff;
    assign RRESP = rresp_ff;
    assign IRQ_REQ = irq_req_ff;
    assign WAKE_REQ = wake_ff;
    assign PUSH_RETURN = vector_ff;
    assign VECTOR_LOAD = vector_ff;
    assign VECTOR_PC = vector_pc_ff;
    assign PHASE = phase_ff;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_taken;
        take;
    endsequence
    // two full instruction cycles after the take, plus the output register
    sequence s_vector;
        ##9 vector_ff;
    endsequence

    property p_entry_latency;
        @(posedge MCLK) disable iff (!RST_N) s_taken |-> s_vector;
    endproperty
    a_entry_latency: assert property (p_entry_latency) else $error("vector not loaded in time");

    property p_global_cleared;
        @(posedge MCLK) disable iff (!RST_N) take |=> !ctrl_ff[irq_ctrl_pkg::B_GLOBAL_EN];
    endproperty
    a_global_cleared: assert property (p_global_cleared) else $error("global enable kept on entry");

    property p_return_sets;
        @(posedge MCLK) disable iff (!RST_N)
            RETURN_FROM_HANDLER && !take |=> ctrl_ff[irq_ctrl_pkg::B_GLOBAL_EN];
    endproperty
    a_return_sets: assert property (p_return_sets) else $error("return did not set enable");

    property p_no_take_global_off;
        @(posedge MCLK) disable iff (!RST_N)
            !ctrl_ff[irq_ctrl_pkg::B_GLOBAL_EN] && state_ff == irq_ctrl_pkg::ST_IDLE
            |=> state_ff == irq_ctrl_pkg::ST_IDLE;
    endproperty
    a_no_take_global_off: assert property (p_no_take_global_off) else $error("entry with enable clear");

    property p_write_clear_blocks;
        @(posedge MCLK) disable iff (!RST_N)
            global_clear_write && state_ff == irq_ctrl_pkg::ST_IDLE |=> state_ff == irq_ctrl_pkg::ST_IDLE;
    endproperty
    a_write_clear_blocks: assert property (p_write_clear_blocks) else $error("entry despite clear");

    property p_timer0_flag;
        @(posedge MCLK) disable iff (!RST_N) TIMER0_ROLLOVER |=> ctrl_ff[irq_ctrl_pkg::B_TIMER0_FLAG];
    endproperty
    a_timer0_flag: assert property (p_timer0_flag) else $error("timer0 flag not set");

    property p_adc_flag;
        @(posedge MCLK) disable iff (!RST_N) CONVERSION_DONE |=> pflags_ff[irq_ctrl_pkg::B_ADC];
    endproperty
    a_adc_flag: assert property (p_adc_flag) else $error("conversion flag not set");

    property p_ext_flag;
        @(posedge MCLK) disable iff (!RST_N) ext_edge |-> ##[1:3] ctrl_ff[irq_ctrl_pkg::B_EXTIF];
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("pin flag not set by edge");

    property p_vector_addr;
        @(posedge MCLK) disable iff (!RST_N) vector_ff |-> vector_pc_ff == irq_ctrl_pkg::VECTOR_ADDR;
    endproperty
    a_vector_addr: assert property (p_vector_addr) else $error("wrong vector address");
endmodule

// file: dv/core_event_model.sv
// Purpose: core sequencer and peripheral event sources
// Assumes: bench commands are one-cycle levels set after an edge
// Notes: commands pass through one register, so each pulse lags its command by one cycle
`timescale 1ns/10ps
module core_event_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bench commands
    input wire logic [4:0] fire,
    input wire logic ret_req,
    // controller side
    input wire logic vector_load,
    input wire logic push_return,
    output logic [4:0] events,
    output logic ret_pulse,
    output int entries,
    output int pair_bad
);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            events <= 5'h00;
            ret_pulse <= 1'h0;
            entries <= 0;
            pair_bad <= 0;
        end
        else
        begin
            events <= fire;
            ret_pulse <= ret_req;
            entries <= entries + int'(vector_load === 1'h1);
            // a jump without its push would lose the return address
            pair_bad <= pair_bad + int'(vector_load !== push_return);
        end
    end
endmodule

// file: dv/mcu_interrupt_controller_test.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: byte address is four times the register index
// Notes: entry latency bound is loose since entry waits for phase one
`timescale 1ns/10ps
module mcu_interrupt_controller_test;
    localparam logic [11:0] ctl = irq_ctrl_pkg::IDX_INTERRUPT_CONTROL;
    localparam logic [11:0] flg = irq_ctrl_pkg::IDX_PERIPHERAL_FLAGS;
    localparam logic [11:0] ena = irq_ctrl_pkg::IDX_PERIPHERAL_ENABLES;
    localparam logic [11:0] opt = irq_ctrl_pkg::IDX_OPTION;
    localparam logic [11:0] pce = irq_ctrl_pkg::IDX_PIN_CHANGE_ENABLES;
    logic mclk = 1'h0, rst_n = 1'h0;
    logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
    logic [31:0] wdata = 32'h0000_0000, rdata, d;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, irq_req, wake_req, push_return, vector_load, ret_pulse;
    logic [1:0] bresp, rresp, phase, r, b;
    logic [12:0] vector_pc;
    logic ext_pin = 1'h0, ret_req = 1'h0, sleeping = 1'h0;
    logic [5:0] port_pins = 6'h00;
    logic [4:0] fire = 5'h00, events;
    int entries, pair_bad, n_errors = 0, n_checks = 0, cyc = 0, c;

    always #10 mclk = ~mclk;

    mcu_interrupt_controller u_dut (
        .MCLK(mclk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .EXT_IRQ_PIN(ext_pin), .PORT_PINS(port_pins),
        .TIMER0_ROLLOVER(events[0]), .COMPARATOR_CHANGE(events[1]), .CONVERSION_DONE(events[2]),
        .TIMER1_ROLLOVER(events[3]), .NVM_WRITE_DONE(events[4]), .RETURN_FROM_HANDLER(ret_pulse),
        .SLEEPING(sleeping), .IRQ_REQ(irq_req), .WAKE_REQ(wake_req), .PUSH_RETURN(push_return),
        .VECTOR_LOAD(vector_load), .VECTOR_PC(vector_pc), .PHASE(phase));

    core_event_model u_model (
        .clk(mclk), .rst_n(rst_n), .fire(fire), .ret_req(ret_req), .vector_load(vector_load),
        .push_return(push_return), .events(events), .ret_pulse(ret_pulse), .entries(entries),
        .pair_bad(pair_bad));

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // address and data go out together; each is dropped once taken
    task automatic wr(input logic [11:0] idx, input logic [7:0] v);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h00_0000, v};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge mclk);
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
        end
        while (bvalid !== 1'h1);
        b = bresp;
        bready <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [11:0] idx);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge mclk);
            if (arready)
                arvalid <= 1'h0;
        end
        while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic rchk(input logic [11:0] idx, input logic [7:0] e);
        rd(idx);
        chk(d, {24'h00_0000, e});
    endtask

    task automatic pulse(input logic [4:0] m);
        fire <= m;
        @(posedge mclk);
        fire <= 5'h00;
    endtask

    task automatic wait_vec;
        c = 0;
        while (vector_load !== 1'h1 && c < 40)
        begin
            @(posedge mclk);
            c++;
        end
    endtask

    // the whole run needs a few hundred cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            close_out;
        end
    end

    initial
    begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (2) @(posedge mclk);
        rchk(ctl, 8'h00);
        rchk(flg, 8'h00);
        rchk(ena, 8'h00);
        rchk(opt, 8'hff);
        rd(12'h001);
        chk({30'h0, r}, {30'h0, irq_ctrl_pkg::RESP_SLVERR});
        chk(d, 32'h0000_0000);
        wr(12'h001, 8'h00);
        chk({30'h0, b}, {30'h0, irq_ctrl_pkg::RESP_SLVERR});
        d = {30'h0, phase + 2'h1};
        @(posedge mclk);
        chk({30'h0, phase}, d);
        $display("test reset values done");
        pulse(5'h1f);
        repeat (4) @(posedge mclk);
        rchk(ctl, 8'h04);
        rchk(flg, irq_ctrl_pkg::PERIPH_MASK);
        chk({31'h0, irq_req}, 32'h0);
        wr(flg, 8'h00);
        wr(ctl, 8'h00);
        chk({30'h0, b}, {30'h0, irq_ctrl_pkg::RESP_OKAY});
        rchk(flg, 8'h00);
        ext_pin <= 1'h1;
        repeat (6) @(posedge mclk);
        rchk(ctl, 8'h02);
        wr(opt, 8'h00);
        wr(ctl, 8'h00);
        ext_pin <= 1'h0;
        repeat (6) @(posedge mclk);
        rchk(ctl, 8'h02);
        wr(ctl, 8'h00);
        ext_pin <= 1'h1;
        repeat (6) @(posedge mclk);
        rchk(ctl, 8'h00);
        $display("test flags and pin edge done");
        wr(pce, 8'h01);
        port_pins <= 6'h02;
        repeat (6) @(posedge mclk);
        rchk(ctl, 8'h00);
        // two changes in different phases, so at most one can be lost
        port_pins <= 6'h03;
        repeat (3) @(posedge mclk);
        port_pins <= 6'h02;
        repeat (6) @(posedge mclk);
        rchk(ctl, 8'h01);
        wr(ctl, 8'ha0);
        pulse(5'h01);
        wait_vec;
        chk({31'h0, c > 3 && c < 17}, 32'h1);
        chk({19'h0, vector_pc}, 32'h0000_0004);
        chk({31'h0, push_return}, 32'h1);
        repeat (2) @(posedge mclk);
        rchk(ctl, 8'h24);
        wr(ctl, 8'h20);
        ret_req <= 1'h1;
        @(posedge mclk);
        ret_req <= 1'h0;
        repeat (4) @(posedge mclk);
        rchk(ctl, 8'ha0);
        wr(ctl, 8'h20);
        pulse(5'h01);
        repeat (16) @(posedge mclk);
        chk(entries, 1);
        // enable comes back by return one cycle before a clearing write lands in a phase-one cycle
        while (phase !== irq_ctrl_pkg::PH_TWO)
            @(posedge mclk);
        ret_req <= 1'h1;
        @(posedge mclk);
        ret_req <= 1'h0;
        wr(ctl, 8'h24);
        repeat (12) @(posedge mclk);
        chk(entries, 1);
        rchk(ctl, 8'h24);
        wr(ctl, 8'ha4);
        wait_vec;
        chk({31'h0, vector_load}, 32'h1);
        wr(ctl, 8'h00);
        $display("test entry and return done");
        wr(ena, 8'h40);
        wr(ctl, 8'h80);
        pulse(5'h04);
        repeat (16) @(posedge mclk);
        chk({31'h0, irq_req}, 32'h0);
        wr(ctl, 8'hc0);
        wait_vec;
        chk({31'h0, vector_load}, 32'h1);
        wr(flg, 8'h00);
        sleeping <= 1'h1;
        wr(ctl, 8'h10);
        ext_pin <= 1'h0;
        repeat (8) @(posedge mclk);
        chk({30'h0, wake_req, irq_req}, 32'h2);
        wr(ctl, 8'h92);
        wait_vec;
        chk({31'h0, vector_load}, 32'h1);
        sleeping <= 1'h0;
        repeat (4) @(posedge mclk);
        chk(entries, 4);
        chk(pair_bad, 0);
        $display("test peripheral and wake done");
        close_out;
    end
endmodule
